/* rtl/write_guard_pkg.sv */
// package: register map, field layout and reset values of the program memory write guard
`default_nettype none
package write_guard_pkg;
   // axi4-lite register byte offsets
   localparam logic [7:0] CFG_OFF = 8'h00;
   localparam logic [7:0] CFG_SHADOW_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] COUNT_OFF = 8'h0c;
   // configuration word fields
   localparam int PTR_LSB = 0;
   localparam int PTR_W = 8;
   localparam int BND_BIT = 8;
   localparam int DIS_BIT = 9;
   localparam int LAST_BIT = 10;
   localparam int WRP_BIT = 11;
   localparam int CP_BIT = 12;
   localparam int CFG_W = 13;
   // erased-cell reset value: every protection off
   localparam logic [12:0] CFG_RST = 13'h1fff;
   // status fields
   localparam int ST_PERR_BIT = 0;
   localparam int ST_BLOCK_BIT = 1;
   // code page size in words as a shift
   localparam int PAGE_SHIFT = 9;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* rtl/segment_range_check.sv */
// leaf: decides whether one program memory word address lies in a protected area
`default_nettype none
module segment_range_check
   import write_guard_pkg::*;
#(
   parameter int ADDR_W = 17,
   parameter int LAST_PAGE = 255
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [PTR_W-1:0] page_ptr,
   input wire logic seg_disable,
   input wire logic bound_select,
   input wire logic last_page_n,
   output logic in_segment
);
   logic [ADDR_W-PAGE_SHIFT-1:0] page;
   logic seg_hit;
   logic last_hit;
   assign page = addr[ADDR_W-1:PAGE_SHIFT];
   // the pointer page is inclusive at either boundary
   assign seg_hit = bound_select ? (page >= (ADDR_W-PAGE_SHIFT)'(page_ptr))
                                 : (page <= (ADDR_W-PAGE_SHIFT)'(page_ptr));
   assign last_hit = (page == (ADDR_W-PAGE_SHIFT)'(LAST_PAGE));
   // segment only when disable is zero; last page protected independently
   assign in_segment = (!seg_disable && seg_hit) || (!last_page_n && last_hit);
endmodule
`default_nettype wire

/* rtl/program_memory_write_guard.sv */
// top: program memory write/erase/external-read guard with configuration shadow check
`default_nettype none
module program_memory_write_guard
   import write_guard_pkg::*;
#(
   parameter int ADDR_W = 17,
   parameter int LAST_PAGE = 255
) (
   input wire logic clk,
   input wire logic nrst,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration word load from program memory
   input wire logic cfg_load,
   input wire logic [CFG_W-1:0] cfg_word,
   // internal write/erase request from the nvm controller
   input wire logic nvm_req,
   input wire logic [ADDR_W-1:0] nvm_addr,
   output logic nvm_done,
   output logic nvm_interlock_en,
   output logic nvm_blocked,
   // external programmer port
   input wire logic ext_req,
   input wire logic ext_write,
   output logic ext_grant,
   output logic ext_deny,
   // fault reset to the reset controller
   output logic cfg_parity_reset
);
   ////////////////////////////////////////////////////////////////////////////
   // configuration register, its complement shadow and derived settings
   logic [CFG_W-1:0] cfg_r;
   logic [CFG_W-1:0] cfg_nxt;
   logic [CFG_W-1:0] shadow_r;
   logic [CFG_W-1:0] shadow_nxt;
   logic [CFG_W-1:0] flip_r;
   logic [CFG_W-1:0] flip_nxt;
   logic whole_memory_code_protect;
   logic whole_memory_write_protect;
   logic segment_protect_disable;
   logic segment_boundary_select;
   logic last_page_protect;
   logic [PTR_W-1:0] segment_page_pointer;
   logic parity_err;

   // only code protect is decoded to a positive meaning here; the other settings keep their raw polarity
   assign whole_memory_code_protect = !cfg_r[CP_BIT];
   assign whole_memory_write_protect = cfg_r[WRP_BIT];
   assign segment_protect_disable = cfg_r[DIS_BIT];
   assign segment_boundary_select = cfg_r[BND_BIT];
   assign last_page_protect = cfg_r[LAST_BIT];
   assign segment_page_pointer = cfg_r[PTR_LSB +: PTR_W];
   // both copies are loaded together so they stay complements
   assign cfg_nxt = cfg_load ? cfg_word : (cfg_r ^ flip_r);
   assign shadow_nxt = cfg_load ? ~cfg_word : shadow_r;
   // continuous compare: any bit not complemented is a disturbed cell
   assign parity_err = ((cfg_r ^ shadow_r) != {CFG_W{1'b1}});

   ////////////////////////////////////////////////////////////////////////////
   // protection decode
   logic in_segment;
   logic wr_block;
   logic ext_block;

   segment_range_check #(
      .ADDR_W(ADDR_W),
      .LAST_PAGE(LAST_PAGE)
   ) range_u (
      .addr(nvm_addr),
      .page_ptr(segment_page_pointer),
      .seg_disable(segment_protect_disable),
      .bound_select(segment_boundary_select),
      .last_page_n(last_page_protect),
      .in_segment(in_segment)
   );

   // segment hit is or-ed on, never masks the whole-memory block
   assign wr_block = (whole_memory_write_protect == 1'b0) || in_segment;
   // external access to any word, config words included
   assign ext_block = whole_memory_code_protect;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: one write and one read under way at most
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic ar_take;
   logic wr_hit_flip;
   logic wr_hit_clr;
   logic rd_known;
   logic [31:0] rd_word;

   // status and counters
   logic perr_sticky_r;
   logic perr_sticky_nxt;
   logic last_block_r;
   logic [15:0] block_cnt_r;
   logic [15:0] block_cnt_nxt;

   assign aw_take = s_axi_awvalid && awready_r;
   assign w_take = s_axi_wvalid && wready_r;
   assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
   assign ar_take = s_axi_arvalid && arready_r;
   // fault injection register: toggles config bits to exercise the checker
   assign wr_hit_flip = wr_fire && (awaddr_r == CFG_SHADOW_OFF) && wstrb_r[0];
   assign wr_hit_clr = wr_fire && (awaddr_r == STATUS_OFF) && wstrb_r[0];
   assign flip_nxt = wr_hit_flip ? wdata_r[CFG_W-1:0] : '0;
   assign rd_known = (s_axi_araddr == CFG_OFF) || (s_axi_araddr == CFG_SHADOW_OFF)
                  || (s_axi_araddr == STATUS_OFF) || (s_axi_araddr == COUNT_OFF);
   assign rd_word = (s_axi_araddr == CFG_OFF) ? 32'(cfg_r)
                  : (s_axi_araddr == CFG_SHADOW_OFF) ? 32'(shadow_r)
                  : (s_axi_araddr == STATUS_OFF) ? {30'h0, last_block_r, perr_sticky_r}
                  : (s_axi_araddr == COUNT_OFF) ? {16'h0, block_cnt_r} : 32'h0;
   // sticky fault: a new error wins over a software clear in the same cycle
   assign perr_sticky_nxt = parity_err ? 1'b1
                          : (wr_hit_clr && wdata_r[ST_PERR_BIT]) ? 1'b0 : perr_sticky_r;

   // address and data channels captured independently, in either order
   always_ff @(posedge clk) begin
      if (!nrst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
         awready_r <= !aw_hold_r && !aw_take && !bvalid_r;
         wready_r <= !w_hold_r && !w_take && !bvalid_r;
      end
   end

   // write response; unmapped or read-only offsets answer slverr
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= (awaddr_r == CFG_SHADOW_OFF || awaddr_r == STATUS_OFF) ? RESP_OKAY
                                                                          : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read channel: one cycle from address to data
   always_ff @(posedge clk) begin
      if (!nrst) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end else begin
         arready_r <= !rvalid_r && !ar_take;
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration state, nvm and external port decisions
   logic nvm_done_r;
   logic interlock_r;
   logic blocked_r;
   logic ext_grant_r;
   logic ext_deny_r;
   logic preset_r;

   assign block_cnt_nxt = block_cnt_r + 16'h0001;

   // erased reset value leaves every protection off until the words load
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_r <= CFG_RST;
         shadow_r <= ~CFG_RST;
         flip_r <= '0;
         perr_sticky_r <= 1'b0;
         preset_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         shadow_r <= shadow_nxt;
         flip_r <= flip_nxt;
         perr_sticky_r <= perr_sticky_nxt;
         preset_r <= parity_err;
      end
   end

   // one-cycle decision per request; a blocked request still completes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         nvm_done_r <= 1'b0;
         interlock_r <= 1'b0;
         blocked_r <= 1'b0;
         last_block_r <= 1'b0;
         block_cnt_r <= 16'h0;
      end else begin
         nvm_done_r <= nvm_req;
         interlock_r <= nvm_req && !wr_block;
         blocked_r <= nvm_req && wr_block;
         if (nvm_req) begin
            last_block_r <= wr_block;
         end
         if (nvm_req && wr_block && block_cnt_r != 16'hffff) begin
            block_cnt_r <= block_cnt_nxt;
         end
      end
   end

   // external programmer reads and writes refused while code protect set
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ext_grant_r <= 1'b0;
         ext_deny_r <= 1'b0;
      end else begin
         ext_grant_r <= ext_req && !ext_block && !(ext_write && wr_block_ext(cfg_r));
         ext_deny_r <= ext_req && (ext_block || (ext_write && wr_block_ext(cfg_r)));
      end
   end

   // external writes honour the write protect setting too
   function automatic logic wr_block_ext(input logic [CFG_W-1:0] c);
      wr_block_ext = !c[WRP_BIT];
   endfunction

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign nvm_done = nvm_done_r;
   assign nvm_interlock_en = interlock_r;
   assign nvm_blocked = blocked_r;
   assign ext_grant = ext_grant_r;
   assign ext_deny = ext_deny_r;
   assign cfg_parity_reset = preset_r;
endmodule
`default_nettype wire

/* dv/write_guard_monitor.sv */
// checker: guard decisions against the configuration word as loaded
`default_nettype none
module write_guard_monitor
   import write_guard_pkg::*;
#(
   parameter int ADDR_W = 17,
   parameter int LAST_PAGE = 255
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cfg_load,
   input wire logic [CFG_W-1:0] cfg_word,
   input wire logic nvm_req,
   input wire logic [ADDR_W-1:0] nvm_addr,
   input wire logic nvm_done,
   input wire logic nvm_interlock_en,
   input wire logic nvm_blocked,
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic ext_grant,
   input wire logic ext_deny,
   input wire logic cfg_parity_reset
);
   logic [CFG_W-1:0] cfg_r;
   // expected decision; injected faults are not followed, so none after a fault
   wire logic [ADDR_W-PAGE_SHIFT-1:0] pg = nvm_addr[ADDR_W-1:PAGE_SHIFT];
   wire logic [7:0] ptr = cfg_r[PTR_W-1:0];
   wire logic seg = !cfg_r[DIS_BIT] && (cfg_r[BND_BIT] ? pg >= ptr : pg <= ptr);
   wire logic lastp = !cfg_r[LAST_BIT] && pg == (ADDR_W-PAGE_SHIFT)'(LAST_PAGE);
   wire logic ok = cfg_r[WRP_BIT] && !seg && !lastp;
   wire logic ext_ok = cfg_r[CP_BIT] && !(ext_write && !cfg_r[WRP_BIT]);
   // copy of the loaded word
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_r <= CFG_RST;
      end else if (cfg_load) begin
         cfg_r <= cfg_word;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_done_follows: assert property (nvm_req |=> nvm_done)
      else $error("request not completed");
   a_one_verdict: assert property (nvm_done |-> nvm_interlock_en != nvm_blocked)
      else $error("done without a single verdict");
   a_wrp_blocks: assert property (nvm_req && !cfg_r[WRP_BIT] |=> nvm_blocked)
      else $error("write protect not applied");
   a_seg_blocks: assert property (nvm_req && seg |=> !nvm_interlock_en)
      else $error("segment write unlocked");
   a_last_blocks: assert property (nvm_req && lastp |=> nvm_blocked)
      else $error("last page not protected");
   a_free_allows: assert property (nvm_req && ok |=> nvm_interlock_en)
      else $error("unprotected write refused");
   a_ext_grant: assert property (ext_req && ext_ok |=> ext_grant && !ext_deny)
      else $error("external access wrongly denied");
   a_ext_deny: assert property (ext_req && !ext_ok |=> ext_deny && !ext_grant)
      else $error("external access wrongly granted");
   a_load_clean: assert property (cfg_load |-> ##2 !cfg_parity_reset)
      else $error("fault reset after clean load");
   c_seg: cover property (nvm_req && seg);
   c_last: cover property (nvm_req && lastp && !seg);
   c_deny: cover property (ext_req && !ext_ok);
   c_fault: cover property (cfg_parity_reset);
endmodule
bind program_memory_write_guard write_guard_monitor #(
   .ADDR_W(ADDR_W),
   .LAST_PAGE(LAST_PAGE)
) mon_u (
   .clk, .nrst, .cfg_load, .cfg_word, .nvm_req, .nvm_addr, .nvm_done, .nvm_interlock_en,
   .nvm_blocked, .ext_req, .ext_write, .ext_grant, .ext_deny, .cfg_parity_reset
);
`default_nettype wire

/* dv/nvm_ctrl_model.sv */
// flash write/erase controller model: issues requests and counts cell writes
`default_nettype none
module nvm_ctrl_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [16:0] go_addr,
   input wire logic nvm_interlock_en,
   output logic nvm_req,
   output logic [16:0] nvm_addr,
   output int wr_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      nvm_req = 0;
      nvm_addr = '0;
      wr_cnt = 0;
   end
   // idle address scrambles each cycle so a stale value never helps the guard
   always @(posedge clk) begin
      nvm_req <= go;
      nvm_addr <= go ? go_addr : ~nvm_addr;
      if (nvm_interlock_en) wr_cnt <= wr_cnt + 1;
   end
endmodule
`default_nettype wire

/* dv/tb_program_memory_write_guard.sv */
// bench: random configurations and addresses, register and fault checks
`default_nettype none
`define CHK(n, e, g) \
   begin \
      n_compared++; \
      if ((e) !== (g)) begin \
         error_cnt++; \
         $display("wrong value %s exp %h got %h", n, e, g); \
      end \
   end
module tb_program_memory_write_guard
   import write_guard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cfg_load;
   logic nvm_req, nvm_done, nvm_interlock_en, nvm_blocked, ext_req, ext_write, ext_grant;
   logic ext_deny, cfg_parity_reset, go, x, g;
   logic [7:0] s_axi_awaddr, s_axi_araddr, pg;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [31:0] q[$];
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, e;
   logic [12:0] cfg_word, w;
   logic [16:0] nvm_addr, go_addr, a;
   int error_cnt, n_compared, nblk, nallow, wr_cnt;
   program_memory_write_guard #(.ADDR_W(17), .LAST_PAGE(255)) dut_u (
      .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cfg_load, .cfg_word, .nvm_req, .nvm_addr, .nvm_done, .nvm_interlock_en, .nvm_blocked,
      .ext_req, .ext_write, .ext_grant, .ext_deny, .cfg_parity_reset
   );
   nvm_ctrl_model pm_u (.clk, .go, .go_addr, .nvm_interlock_en, .nvm_req, .nvm_addr, .wr_cnt);
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // every result pops the oldest note; an empty queue means an unexpected result
   task automatic check(logic [31:0] got);
      logic [31:0] ex;
      ex = (q.size() == 0) ? 32'hdeadbeef : q.pop_front();
      `CHK("result", ex, got)
   endtask
   always @(posedge clk) begin
      if (nvm_done === 1'b1) check({30'h0, nvm_interlock_en, nvm_blocked});
      if ((ext_grant | ext_deny) === 1'b1) check({30'h0, ext_grant, ext_deny});
      if ((s_axi_bvalid & s_axi_bready) === 1'b1) check(32'(s_axi_bresp));
      if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
         check(s_axi_rdata);
         // only the four aligned offsets of the map answer okay
         `CHK("rresp", (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= COUNT_OFF) ? RESP_OKAY : RESP_SLVERR, s_axi_rresp)
      end
   end
   task automatic drain();
      for (int k = 0; k < 20 && q.size() > 0; k++) @(posedge clk);
      if (q.size() > 0) begin
         error_cnt++;
         give_verdict();
      end
   endtask
   // one access; both halves of a write offered together, each dropped when taken
   task automatic axi(logic is_wr, logic [7:0] ad, logic [31:0] d, logic [31:0] ex);
      int k;
      logic fin;
      @(posedge clk);
      q.push_back(ex);
      s_axi_awaddr <= ad;
      s_axi_araddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= is_wr;
      s_axi_wvalid <= is_wr;
      s_axi_bready <= is_wr;
      s_axi_arvalid <= !is_wr;
      s_axi_rready <= !is_wr;
      k = 0;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_arready) s_axi_arvalid <= 0;
         fin = (is_wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1;
         if (fin) begin
            s_axi_bready <= 0;
            s_axi_rready <= 0;
         end
         k++;
      end while (!fin && k < 20);
      drain();
   endtask
   task automatic pulse_req(logic is_nvm, logic [16:0] ad, logic wr, logic [1:0] ex);
      q.push_back(32'(ex));
      go <= is_nvm;
      go_addr <= ad;
      ext_req <= !is_nvm;
      ext_write <= wr;
      @(posedge clk);
      go <= 0;
      ext_req <= 0;
      drain();
   endtask
   // reference decision for one write/erase address
   function automatic logic [1:0] nvm_exp(logic [12:0] c, logic [16:0] ad);
      logic [7:0] p;
      logic b;
      p = ad[16:9];
      b = !c[WRP_BIT] || (!c[DIS_BIT] && (c[BND_BIT] ? p >= c[7:0] : p <= c[7:0]));
      b = b || (!c[LAST_BIT] && p == 8'hff);
      return {!b, b};
   endfunction
   ////////////////////////////////////////////////////////////////
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {cfg_load, ext_req, ext_write, go, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      cfg_word = '0;
      go_addr = '0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge clk);
      nrst <= 1;
      repeat (2) @(posedge clk);
      seed = $urandom(32'h5869);
      axi(0, CFG_OFF, 0, 32'(CFG_RST));
      axi(0, CFG_SHADOW_OFF, 0, 0);
      axi(0, STATUS_OFF, 0, 0);
      axi(0, 8'h10, 0, 0);
      axi(1, CFG_OFF, 0, 32'(RESP_SLVERR));
      $display("test reset and map done");
      // all protection modes, with page edges around the pointer and the last page
      for (int i = 0; i < 64; i++) begin
         w = 13'($urandom);
         w[11:8] = 4'(i);
         cfg_word <= w;
         cfg_load <= 1;
         @(posedge clk);
         cfg_load <= 0;
         pg = w[7:0] + 8'($urandom % 3) - 8'h01;
         if (i % 5 == 0) pg = 8'hff;
         a = {pg, (i[0] ? 9'h1ff : 9'h000)};
         e = nvm_exp(w, a);
         nblk += e[0];
         nallow += e[1];
         pulse_req(1, a, 0, e);
         x = 1'($urandom);
         g = w[CP_BIT] && !(x && !w[WRP_BIT]);
         pulse_req(0, 0, x, {g, !g});
      end
      $display("test protection modes done");
      axi(0, COUNT_OFF, 0, 32'(nblk));
      axi(0, CFG_OFF, 0, 32'(w));
      `CHK("cell writes", nallow, wr_cnt)
      $display("test counts done");
      axi(1, CFG_SHADOW_OFF, 32'h1, 32'(RESP_OKAY));
      for (int k = 0; k < 10 && cfg_parity_reset !== 1'b1; k++) @(posedge clk);
      `CHK("fault reset", 1'b1, cfg_parity_reset)
      // a clear while the fault persists must lose to the standing error
      axi(1, STATUS_OFF, 32'h1, 32'(RESP_OKAY));
      axi(0, STATUS_OFF, 0, {30'h0, e[0], 1'b1});
      axi(0, CFG_OFF, 0, 32'(w ^ 13'h1));
      $display("test fault injection done");
      // mid-run reset must drop the fault reset and restore the erased word
      nrst <= 0;
      repeat (2) @(posedge clk);
      nrst <= 1;
      repeat (2) @(posedge clk);
      `CHK("fault reset after reset", 1'b0, cfg_parity_reset)
      axi(0, STATUS_OFF, 0, 0);
      axi(0, CFG_OFF, 0, 32'(CFG_RST));
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
